// File: bench/tb_top.sv
/*
  Self-checking bench for the start-up and closed-loop configuration bank.
  Assumes mscfg_pkg and the bank are compiled first; the bench drives the
  register port itself and judges the decoded settings.
*/
`timescale 1ns/10ps
module tb_top;
  logic                    clk_sys = 1'b0;
  logic                    nrst    = 1'b0;
  logic [7:0]              addr    = 8'h00;
  logic [31:0]             wdata   = 32'h00000000;
  logic                    wr_stb  = 1'b0;
  logic                    rd_stb  = 1'b0;
  logic [31:0]             rdata;
  mscfg_pkg::mscfg_start_t start_cfg;
  mscfg_pkg::mscfg_loop_t  loop_cfg;
  int                      error_cnt = 0;
  int                      cmp_count = 0;
  localparam logic [7:0]   A_ST = mscfg_pkg::OFS_STARTUP;
  localparam logic [7:0]   A_CL = mscfg_pkg::OFS_CLOSED1;

  // The 40 MHz system clock.
  always #12.5 clk_sys = ~clk_sys;

  mscfg_bank uut
  (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .addr      (addr),
    .wdata     (wdata),
    .wr_stb    (wr_stb),
    .rd_stb    (rd_stb),
    .rdata     (rdata),
    .start_cfg (start_cfg),
    .loop_cfg  (loop_cfg)
  );

  // Compares with case equality so that an unknown never matches.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One write cycle; the strobe drops at the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
    #1;
  endtask

  // One read cycle; data stand one cycle only, then return to zero.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    #1;
    chk(rdata, exp);
    @(posedge clk_sys);
    #1;
    chk(rdata, 32'h00000000);
  endtask

  // Reset value of the closed-loop register and the decoded defaults.
  task automatic t_reset();
    rd(A_CL, 32'h00000000);
    chk(32'(start_cfg.align_deg), 32'h0);
    chk(32'(start_cfg.spin_pct_x10), 32'hA);
    chk(32'(start_cfg.first_pct_x10), 32'h0);
    chk(32'(start_cfg.ramp_mdeg_x10), 32'h1);
    chk(32'(loop_cfg.overmod_en), 32'h0);
    chk(32'(loop_cfg.rise_hz_x2), 32'h1);
    chk(32'(loop_cfg.fall_hz_x2), 32'h1);
  endtask

  // Alignment codes, including the uneven steps and reserved codes.
  task automatic t_align();
    logic [4:0] c [9] = '{5'h00, 5'h04, 5'h09, 5'h0B, 5'h19, 5'h1C,
                          5'h1D, 5'h1E, 5'h1F};
    int         d [9] = '{0, 45, 110, 135, 315, 350, 0, 0, 0};
    for (int i = 0; i < 9; i++)
    begin
      wr(A_ST, 32'(c[i]) << 8);
      chk(32'(start_cfg.align_deg), 32'(d[i]));
      chk(32'(start_cfg.align_valid), (i < 6) ? 32'h1 : 32'h0);
    end
  endtask

  // Spin rate codes and the first-cycle source select.
  task automatic t_spin();
    logic [3:0] c [5] = '{4'h0, 4'h3, 4'h4, 4'hA, 4'hF};
    int         p [5] = '{10, 50, 75, 250, 500};
    for (int i = 0; i < 5; i++)
    begin
      wr(A_ST, (32'(c[i]) << 4) | 32'h8);
      chk(32'(start_cfg.spin_pct_x10), 32'(p[i]));
      chk(32'(start_cfg.first_pct_x10), 32'(p[i]));
      wr(A_ST, 32'(c[i]) << 4);
      chk(32'(start_cfg.first_pct_x10), 32'h0);
    end
  endtask

  // Every merge ramp code, with the whole register read back.
  task automatic t_ramp();
    int r [8] = '{1, 5, 10, 15, 20, 50, 100, 200};
    for (int i = 0; i < 8; i++)
    begin
      wr(A_ST, 32'hFFFF_E0F0 | 32'(i));
      chk(32'(start_cfg.ramp_mdeg_x10), 32'(r[i]));
      rd(A_ST, 32'hFFFF_E0F0 | 32'(i));
    end
  endtask

  // Overdrive enable and the rise rate codes up to the limitless one.
  task automatic t_rise();
    logic [4:0]  c [7] = '{5'h00, 5'h01, 5'h02, 5'h05, 5'h13, 5'h1E, 5'h1F};
    logic [16:0] x [7] = '{17'h1, 17'h2, 17'h5, 17'h14, 17'h7D0,
                           17'h1FFFF, 17'h1FFFF};
    for (int i = 0; i < 7; i++)
    begin
      wr(A_CL, (32'(c[i]) << 25) | ((i % 2) ? 32'h4000_0000 : 32'h0));
      chk(32'(loop_cfg.rise_hz_x2), 32'(x[i]));
      chk(32'(loop_cfg.rise_unlimited), (i == 6) ? 32'h1 : 32'h0);
      chk(32'(loop_cfg.overmod_en), 32'(i % 2));
    end
  endtask

  // Fall rate source: own field, rise reuse, and surge guard override.
  task automatic t_fall();
    wr(A_CL, (32'h02 << 25) | (32'h05 << 19));
    chk(32'(loop_cfg.fall_hz_x2), 32'h14);
    wr(A_CL, (32'h02 << 25) | (32'h05 << 19) | 32'h0100_0000);
    chk(32'(loop_cfg.fall_hz_x2), 32'h5);
    wr(A_CL, (32'h02 << 25) | (32'h05 << 19) | 32'h8);
    chk(32'(loop_cfg.fall_hz_x2), 32'h5);
    wr(A_CL, 32'h1F << 19);
    chk(32'(loop_cfg.fall_unlimited), 32'h1);
    chk(32'(loop_cfg.rise_unlimited), 32'h0);
  endtask

  // A write followed with no gap by a read of the same register.
  task automatic t_b2b();
    @(posedge clk_sys);
    addr   <= A_CL;
    wdata  <= 32'h4A5A_0008;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    #1;
    chk(rdata, 32'h4A5A_0008);
    chk(32'(loop_cfg.overmod_en), 32'h1);
  endtask

  // Reserved bits, an unmapped address, and a reset in mid-run.
  task automatic t_misc();
    wr(A_CL, 32'hFFFFFFFF);
    rd(A_CL, 32'hFFFFFFFF);
    wr(8'h40, 32'h12345678);
    rd(8'h40, 32'h00000000);
    rd(A_CL, 32'hFFFFFFFF);
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(A_CL, 32'h00000000);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("compares=%0d mismatches=%0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Main sequence: reset for twelve cycles, then each scenario.
  initial
  begin
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset();
    t_align();
    t_spin();
    t_ramp();
    t_rise();
    t_fall();
    t_b2b();
    t_misc();
    print_verdict();
  end
endmodule // tb_top

// File: common/mscfg_pkg.sv
/*
  Package for the motor start-up and closed-loop configuration bank.
  Holds register offsets, field positions, reset values, the no-limit and
  first reserved codes, and the packed structs that carry decoded settings.
  Assumes a single 40 MHz system clock and a simple strobed register port.
*/
package mscfg_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFS_STARTUP = 8'h86;
  localparam logic [7:0] OFS_CLOSED1 = 8'h88;

  // Reset values.
  localparam logic [31:0] RST_STARTUP = 32'h00000000;
  localparam logic [31:0] RST_CLOSED1 = 32'h00000000;

  // Start-up register field positions.
  localparam int ALIGN_LSB = 8;
  localparam int SPIN_LSB  = 4;
  localparam int RSRC_BIT  = 3;
  localparam int RAMP_LSB  = 0;

  // Closed-loop register field positions.
  localparam int OVM_BIT   = 30;
  localparam int RISE_LSB  = 25;
  localparam int FSRC_BIT  = 24;
  localparam int FALL_LSB  = 19;
  localparam int SURGE_BIT = 3;

  // Rate code that removes the speed change limit.
  localparam logic [4:0] RATE_NO_LIMIT = 5'h1F;

  // First reserved alignment code.
  localparam logic [4:0] ALIGN_RSVD_MIN = 5'h1D;

  // Decoded start-up settings.
  typedef struct packed {
    logic [8:0]  align_deg;
    logic        align_valid;
    logic [9:0]  spin_pct_x10;
    logic [9:0]  first_pct_x10;
    logic [7:0]  ramp_mdeg_x10;
  } mscfg_start_t;

  // Decoded closed-loop settings.
  typedef struct packed {
    logic        overmod_en;
    logic [16:0] rise_hz_x2;
    logic        rise_unlimited;
    logic [16:0] fall_hz_x2;
    logic        fall_unlimited;
  } mscfg_loop_t;

endpackage

// File: design/mscfg_bank.sv
/*
  Configuration bank for start-up angle and closed-loop speed settings of a
  sensorless motor controller, with decoders that present the settings to
  the control core as packed structs.
  Assumes a strobed register port on clk_sys; read data the cycle after.
*/
// The implementer's own choice: the plain strobed port.
// Summary of operation
// R01 - Alignment code in bits 12-8 maps to 0..350 deg; 1Dh-1Fh are reserved.
// R02 - Spin rate code in bits 7-4 maps to 1% up to 50% of top speed.
// R03 - First open-loop cycle runs at 0 Hz unless bit 3 selects spin rate.
// R04 - Angle merge ramp rate in bits 2-0 runs from 0.01 to 2 deg/ms.
// R05 - Closed-loop register sits at 88h and resets to all zeros.
// R06 - Bit 30 of the closed-loop register turns overdrive modulation on.
// R07 - Speed rise is limited by the rate code in bits 29-25.
// R08 - Bit 24 clear uses the fall rate field, set reuses the rise rate.
// R09 - Fall rate field is used only with surge guard off and bit 24 clear.
// R10 - Reserved bits are stored and read back with no effect.
`timescale 1ns/10ps
module mscfg_bank
(
  // Clock and reset.
  input  wire logic                  clk_sys,
  input  wire logic                  nrst,
  // Register port.
  input  wire logic [7:0]            addr,
  input  wire logic [31:0]           wdata,
  input  wire logic                  wr_stb,
  input  wire logic                  rd_stb,
  output logic      [31:0]           rdata,
  // Decoded settings towards the control core.
  output mscfg_pkg::mscfg_start_t    start_cfg,
  output mscfg_pkg::mscfg_loop_t     loop_cfg
);

  logic [31:0] startup_r;
  logic [31:0] closed1_r;
  logic [31:0] rdata_r;
  logic [4:0]  align_code;
  logic [3:0]  spin_code;
  logic [2:0]  ramp_code;
  logic [4:0]  rise_code;
  logic [4:0]  fall_code;
  logic [4:0]  decel_code;
  logic [16:0] rise_rate;
  logic        rise_unl;
  logic [16:0] fall_rate;
  logic        fall_unl;
  logic        surge_on;

  // Alignment angle table in degrees; reserved codes report zero.
  function automatic logic [8:0] align_deg_f(input logic [4:0] c);
    unique case (c)
      5'h00: align_deg_f = 9'h000;
      5'h01: align_deg_f = 9'h00A;
      5'h02: align_deg_f = 9'h014;
      5'h03: align_deg_f = 9'h01E;
      5'h04: align_deg_f = 9'h02D;
      5'h05: align_deg_f = 9'h03C;
      5'h06: align_deg_f = 9'h046;
      5'h07: align_deg_f = 9'h050;
      5'h08: align_deg_f = 9'h05A;
      5'h09: align_deg_f = 9'h06E;
      5'h0A: align_deg_f = 9'h078;
      5'h0B: align_deg_f = 9'h087;
      5'h0C: align_deg_f = 9'h096;
      5'h0D: align_deg_f = 9'h0A0;
      5'h0E: align_deg_f = 9'h0AA;
      5'h0F: align_deg_f = 9'h0B4;
      5'h10: align_deg_f = 9'h0BE;
      5'h11: align_deg_f = 9'h0D2;
      5'h12: align_deg_f = 9'h0E1;
      5'h13: align_deg_f = 9'h0F0;
      5'h14: align_deg_f = 9'h0FA;
      5'h15: align_deg_f = 9'h104;
      5'h16: align_deg_f = 9'h10E;
      5'h17: align_deg_f = 9'h118;
      5'h18: align_deg_f = 9'h122;
      5'h19: align_deg_f = 9'h13B;
      5'h1A: align_deg_f = 9'h14A;
      5'h1B: align_deg_f = 9'h154;
      5'h1C: align_deg_f = 9'h15E;
      default: align_deg_f = 9'h000;
    endcase
  endfunction

  // Spin rate table in tenths of a percent of top speed.
  function automatic logic [9:0] spin_pct_f(input logic [3:0] c);
    unique case (c)
      4'h0: spin_pct_f = 10'h00A;
      4'h1: spin_pct_f = 10'h014;
      4'h2: spin_pct_f = 10'h01E;
      4'h3: spin_pct_f = 10'h032;
      4'h4: spin_pct_f = 10'h04B;
      4'h5: spin_pct_f = 10'h064;
      4'h6: spin_pct_f = 10'h07D;
      4'h7: spin_pct_f = 10'h096;
      4'h8: spin_pct_f = 10'h0AF;
      4'h9: spin_pct_f = 10'h0C8;
      4'hA: spin_pct_f = 10'h0FA;
      4'hB: spin_pct_f = 10'h12C;
      4'hC: spin_pct_f = 10'h15E;
      4'hD: spin_pct_f = 10'h190;
      4'hE: spin_pct_f = 10'h1C2;
      4'hF: spin_pct_f = 10'h1F4;
    endcase
  endfunction

  // Ramp table in units of 0.01 deg/ms.
  function automatic logic [7:0] ramp_f(input logic [2:0] c);
    unique case (c)
      3'h0: ramp_f = 8'h01;
      3'h1: ramp_f = 8'h05;
      3'h2: ramp_f = 8'h0A;
      3'h3: ramp_f = 8'h0F;
      3'h4: ramp_f = 8'h14;
      3'h5: ramp_f = 8'h32;
      3'h6: ramp_f = 8'h64;
      3'h7: ramp_f = 8'hC8;
    endcase
  endfunction

  // Start-up register; every bit is stored, reserved ones included.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      startup_r <= mscfg_pkg::RST_STARTUP;
    else if (wr_stb && addr == mscfg_pkg::OFS_STARTUP)
      startup_r <= wdata; // R10
  end

  // Closed-loop register at its fixed offset, cleared by reset.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      closed1_r <= mscfg_pkg::RST_CLOSED1; // R05
    else if (wr_stb && addr == mscfg_pkg::OFS_CLOSED1)
      closed1_r <= wdata; // R05
  end

  // Read data for the cycle after the strobe; unmapped offsets read zero.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      rdata_r <= 32'h00000000;
    else if (rd_stb)
    begin
      unique case (addr)
        mscfg_pkg::OFS_STARTUP: rdata_r <= startup_r; // R10
        mscfg_pkg::OFS_CLOSED1: rdata_r <= closed1_r; // R05
        default:                rdata_r <= 32'h00000000;
      endcase
    end
    else
      rdata_r <= 32'h00000000;
  end

  assign rdata = rdata_r;

  // Field slices.
  assign align_code = startup_r[mscfg_pkg::ALIGN_LSB +: 5];
  assign spin_code  = startup_r[mscfg_pkg::SPIN_LSB +: 4];
  assign ramp_code  = startup_r[mscfg_pkg::RAMP_LSB +: 3];
  assign rise_code  = closed1_r[mscfg_pkg::RISE_LSB +: 5];
  assign fall_code  = closed1_r[mscfg_pkg::FALL_LSB +: 5];
  assign surge_on   = closed1_r[mscfg_pkg::SURGE_BIT];

  // Deceleration source: the separate field only when it is selected and
  // surge guard leaves the fall rate to software.
  always_comb
  begin
    if (!closed1_r[mscfg_pkg::FSRC_BIT] && !surge_on) // R08 R09
      decel_code = fall_code; // R09
    else
      decel_code = rise_code; // R08
  end

  // Shared rate table for rise and fall limits.
  mscfg_rate_lut u_rise_lut
  (
    .code      (rise_code),
    .rate_x2   (rise_rate),
    .unlimited (rise_unl)
  );

  mscfg_rate_lut u_fall_lut
  (
    .code      (decel_code),
    .rate_x2   (fall_rate),
    .unlimited (fall_unl)
  );

  // Start-up settings towards the core; the first cycle is held at zero
  // unless the source bit picks the spin rate.
  always_comb
  begin
    start_cfg.align_deg     = align_deg_f(align_code); // R01
    start_cfg.align_valid   =
      (align_code < mscfg_pkg::ALIGN_RSVD_MIN); // R01
    start_cfg.spin_pct_x10  = spin_pct_f(spin_code); // R02
    start_cfg.first_pct_x10 = startup_r[mscfg_pkg::RSRC_BIT] ?
      spin_pct_f(spin_code) : 10'h000; // R03
    start_cfg.ramp_mdeg_x10 = ramp_f(ramp_code); // R04
  end

  // Closed-loop settings towards the core.
  always_comb
  begin
    loop_cfg.overmod_en     = closed1_r[mscfg_pkg::OVM_BIT]; // R06
    loop_cfg.rise_hz_x2     = rise_rate; // R07
    loop_cfg.rise_unlimited = rise_unl; // R07
    loop_cfg.fall_hz_x2     = fall_rate; // R08
    loop_cfg.fall_unlimited = fall_unl; // R08
  end

  // Checks. The tables are spot-checked at their end points only;
  // repeating every entry here would only copy the functions
  // above and catch nothing that they miss.
  reset_zero_a: assert property ( // R05
    @(posedge clk_sys)
    $rose(nrst) |-> closed1_r == 32'h00000000)
    else $error("closed-loop register not zero after reset");

  offset_write_a: assert property ( // R05
    @(posedge clk_sys) disable iff (!nrst)
    wr_stb && addr == mscfg_pkg::OFS_CLOSED1 |=> closed1_r == $past(wdata))
    else $error("closed-loop write at its offset not stored");

  unmapped_keep_a: assert property ( // R05
    @(posedge clk_sys) disable iff (!nrst)
    wr_stb && addr != mscfg_pkg::OFS_CLOSED1 |=> $stable(closed1_r))
    else $error("closed-loop register changed by another offset");

  write_read_a: assert property ( // R10
    @(posedge clk_sys) disable iff (!nrst)
    wr_stb && addr == mscfg_pkg::OFS_CLOSED1 ##1
    rd_stb && addr == mscfg_pkg::OFS_CLOSED1 && !wr_stb
    |=> rdata == $past(wdata, 2))
    else $error("closed-loop readback mismatch");

  startup_store_a: assert property ( // R10
    @(posedge clk_sys) disable iff (!nrst)
    wr_stb && addr == mscfg_pkg::OFS_STARTUP |=> startup_r == $past(wdata))
    else $error("start-up write not stored whole");

  read_idle_a: assert property ( // R10
    @(posedge clk_sys) disable iff (!nrst)
    !rd_stb |=> rdata == 32'h00000000)
    else $error("read data not cleared after the read cycle");

  overmod_follow_a: assert property ( // R06
    @(posedge clk_sys) disable iff (!nrst)
    wr_stb && addr == mscfg_pkg::OFS_CLOSED1
    |=> loop_cfg.overmod_en == $past(wdata[mscfg_pkg::OVM_BIT]))
    else $error("overmodulation enable not taken");

  first_zero_a: assert property ( // R03
    @(posedge clk_sys) disable iff (!nrst)
    !startup_r[mscfg_pkg::RSRC_BIT] |-> start_cfg.first_pct_x10 == 10'h000)
    else $error("first cycle not held at zero");

  first_spin_a: assert property ( // R03
    @(posedge clk_sys) disable iff (!nrst)
    startup_r[mscfg_pkg::RSRC_BIT]
    |-> start_cfg.first_pct_x10 == start_cfg.spin_pct_x10)
    else $error("first cycle not spin rate");

  align_rsvd_a: assert property ( // R01
    @(posedge clk_sys) disable iff (!nrst)
    align_code >= mscfg_pkg::ALIGN_RSVD_MIN
    |-> !start_cfg.align_valid && start_cfg.align_deg == 9'h000)
    else $error("reserved align code reported valid");

  align_top_a: assert property ( // R01
    @(posedge clk_sys) disable iff (!nrst)
    align_code == 5'h1C |-> start_cfg.align_deg == 9'h15E)
    else $error("top alignment angle wrong");

  spin_span_a: assert property ( // R02
    @(posedge clk_sys) disable iff (!nrst)
    (spin_code == 4'hF |-> start_cfg.spin_pct_x10 == 10'h1F4) and
    (spin_code == 4'h0 |-> start_cfg.spin_pct_x10 == 10'h00A))
    else $error("spin rate end points wrong");

  ramp_span_a: assert property ( // R04
    @(posedge clk_sys) disable iff (!nrst)
    (ramp_code == 3'h7 |-> start_cfg.ramp_mdeg_x10 == 8'hC8) and
    (ramp_code == 3'h0 |-> start_cfg.ramp_mdeg_x10 == 8'h01))
    else $error("ramp rate end points wrong");

  rise_floor_a: assert property ( // R07
    @(posedge clk_sys) disable iff (!nrst)
    rise_code == 5'h00 |-> loop_cfg.rise_hz_x2 == 17'h00001)
    else $error("rise rate floor wrong");

  rise_open_a: assert property ( // R07
    @(posedge clk_sys) disable iff (!nrst)
    loop_cfg.rise_unlimited == (rise_code == mscfg_pkg::RATE_NO_LIMIT))
    else $error("rise limit removal wrong");

  fall_reuse_a: assert property ( // R08
    @(posedge clk_sys) disable iff (!nrst)
    closed1_r[mscfg_pkg::FSRC_BIT]
    |-> loop_cfg.fall_hz_x2 == loop_cfg.rise_hz_x2)
    else $error("fall rate not reusing rise rate");

  surge_reuse_a: assert property ( // R09
    @(posedge clk_sys) disable iff (!nrst)
    surge_on |-> loop_cfg.fall_hz_x2 == loop_cfg.rise_hz_x2)
    else $error("fall field used while surge guard is on");

  fall_sep_a: assert property ( // R09
    @(posedge clk_sys) disable iff (!nrst)
    !closed1_r[mscfg_pkg::FSRC_BIT] && !surge_on
    && fall_code == mscfg_pkg::RATE_NO_LIMIT
    |-> loop_cfg.fall_unlimited)
    else $error("separate fall rate not used");

endmodule // mscfg_bank

// File: design/mscfg_rate_lut.sv
/*
  Rate decoder: turns a 5-bit speed change rate code into half-hertz per
  second units.
  Assumes a purely combinational use inside the configuration bank.
*/
`timescale 1ns/10ps
module mscfg_rate_lut
(
  // Code in.
  input  wire logic [4:0]  code,
  // Rate out, in 0.5 Hz/s units, and the no-limit flag.
  output logic      [16:0] rate_x2,
  output logic             unlimited
);

  // Table of rates; top code means no limit at all.
  always_comb
  begin
    unlimited = 1'b0;
    unique case (code)
      5'h00: rate_x2 = 17'h00001;
      5'h01: rate_x2 = 17'h00002;
      5'h02: rate_x2 = 17'h00005;
      5'h03: rate_x2 = 17'h0000A;
      5'h04: rate_x2 = 17'h0000F;
      5'h05: rate_x2 = 17'h00014;
      5'h06: rate_x2 = 17'h00028;
      5'h07: rate_x2 = 17'h00050;
      5'h08: rate_x2 = 17'h00078;
      5'h09: rate_x2 = 17'h000A0;
      5'h0A: rate_x2 = 17'h000C8;
      5'h0B: rate_x2 = 17'h00190;
      5'h0C: rate_x2 = 17'h00258;
      5'h0D: rate_x2 = 17'h00320;
      5'h0E: rate_x2 = 17'h003E8;
      5'h0F: rate_x2 = 17'h004B0;
      5'h10: rate_x2 = 17'h00578;
      5'h11: rate_x2 = 17'h00640;
      5'h12: rate_x2 = 17'h00708;
      5'h13: rate_x2 = 17'h007D0;
      5'h14: rate_x2 = 17'h00FA0;
      5'h15: rate_x2 = 17'h01F40;
      5'h16: rate_x2 = 17'h02EE0;
      5'h17: rate_x2 = 17'h03E80;
      5'h18: rate_x2 = 17'h04E20;
      5'h19: rate_x2 = 17'h09C40;
      5'h1A: rate_x2 = 17'h0EA60;
      5'h1B: rate_x2 = 17'h13880;
      5'h1C: rate_x2 = 17'h186A0;
      5'h1D: rate_x2 = 17'h1D4C0;
      5'h1E: rate_x2 = 17'h1FFFF;
      5'h1F:
      begin
        rate_x2   = 17'h1FFFF;
        unlimited = 1'b1;
      end
    endcase
  end

endmodule // mscfg_rate_lut
